// ==== design/cfg_msg_pkg.sv ====
// Package of token codes, field widths and destinations for config messages.
package cfg_msg_pkg;
	localparam int TOKEN_W = 8;
	localparam int CHAN_W = 24;
	localparam int REGNUM_W = 16;
	localparam int DATA_W = 32;
	localparam int DEST_W = 32;
	localparam int NO_REPLY_W = 8;
	localparam logic [7:0] TOK_WRITE = 8'hc0;
	localparam logic [7:0] TOK_READ = 8'hc1;
	localparam logic [7:0] TOK_END = 8'h01;
	localparam logic [7:0] TOK_ACK = 8'h03;
	localparam logic [7:0] TOK_NACK = 8'h04;
	localparam logic [15:0] TILE_DEST_LOW = 16'hc20c;
	localparam logic [15:0] NODE_DEST_LOW = 16'hc30c;
	localparam logic [7:0] NO_REPLY_LOW = 8'hff;
	localparam int PS_SHIFT = 8;
	localparam logic [7:0] PS_RES_TYPE = 8'h0b;
	localparam int N_TILE_REGS = 8;
	localparam int N_NODE_REGS = 8;
	localparam int N_PS_REGS = 16;
	localparam logic [15:0] TILE_ID_RESET = 16'h0000;
	localparam logic [15:0] NODE_ID_RESET = 16'h0000;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage : cfg_msg_pkg

// ==== design/cfg_link_if.sv ====
// Interface carrying token-framed messages both ways between the two ends.
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if;
	logic [31:0] req_dest;
	logic req_valid;
	logic req_ctrl;
	logic [7:0] req_byte;
	logic req_ready;
	logic rsp_valid;
	logic rsp_ctrl;
	logic [7:0] rsp_byte;
	logic [23:0] rsp_chan;
	logic rsp_ready;
	modport device (input req_dest, input req_valid, input req_ctrl,
		input req_byte, output req_ready, output rsp_valid, output rsp_ctrl,
		output rsp_byte, output rsp_chan, input rsp_ready);
	modport requester (output req_dest, output req_valid, output req_ctrl,
		output req_byte, input req_ready, input rsp_valid, input rsp_ctrl,
		input rsp_byte, input rsp_chan, output rsp_ready);
endinterface : cfg_link_if
`default_nettype wire

// ==== design/cfg_device.sv ====
// Device end: config registers reached by messages and status register port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Requests carry 24-bit reply channel-end.
// R2: Reply low byte all ones suppresses reply; the code suppresses it for writes only, and reads still get a reply.
// R3: Multi-byte fields travel most significant first.
// R4: Status registers read and written whole words.
// R5: Status resource id is number shl 8 or 0b.
// R6: Tile registers answer destination ending c20c.
// R7: Node registers answer destination ending c30c.
// R8: Write: 192, reply, register, data, 1.
// R9: Read: 193, reply, register, 1.
// R10: Write reply: 3,1 success; 4,1 failure.
// R11: Read reply: 3, data, 1; or 4,1.
// R12: Unknown register or malformed request fails.
module cfg_device (
	input wire logic clock,
	input wire logic rst,
	cfg_link_if.device link,
	input wire logic [15:0] tile_id,
	input wire logic [15:0] node_id,
	input wire logic ps_valid,
	input wire logic ps_write,
	input wire logic [31:0] ps_resource,
	input wire logic [31:0] ps_wdata,
	output logic ps_done,
	output logic ps_error,
	output logic [31:0] ps_rdata,
	output logic busy
);
	import cfg_msg_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CHAN = 3'b001,
		S_REG = 3'b010,
		S_DATA = 3'b011,
		S_END = 3'b100,
		S_DRAIN = 3'b101,
		S_REPLY = 3'b110
	} state_t;

	function automatic logic dest_match(input logic [31:0] dest,
		input logic [15:0] id, input logic [15:0] low);
		dest_match = (dest[31:16] == id) && (dest[15:0] == low);
	endfunction : dest_match

	state_t state, next_state;
	logic is_write, next_is_write;
	logic is_node, next_is_node;
	logic bad, next_bad;
	logic [2:0] count, next_count;
	logic [23:0] chan, next_chan;
	logic [15:0] regnum, next_regnum;
	logic [31:0] data, next_data;
	logic [2:0] rsp_idx, next_rsp_idx;
	logic [2:0] rsp_len, next_rsp_len;
	logic [31:0] tile_regs [N_TILE_REGS];
	logic [31:0] node_regs [N_NODE_REGS];
	logic [31:0] ps_regs [N_PS_REGS];
	logic req_ready, next_req_ready;
	logic rsp_valid, next_rsp_valid;
	logic rsp_ctrl, next_rsp_ctrl;
	logic [7:0] rsp_byte, next_rsp_byte;
	logic do_write, next_do_write;
	logic next_ps_done, next_ps_error;
	logic [31:0] next_ps_rdata;
	logic take;
	logic [15:0] ps_num;
	logic ps_ok;

	assign link.req_ready = req_ready;
	assign link.rsp_valid = rsp_valid;
	assign link.rsp_ctrl = rsp_ctrl;
	assign link.rsp_byte = rsp_byte;
	assign link.rsp_chan = chan;
	assign take = link.req_valid && req_ready;
	assign ps_num = ps_resource[23:8];
	// Low byte must name the status resource type. R5
	assign ps_ok = (ps_resource[7:0] == PS_RES_TYPE) &&
		(ps_resource[31:24] == 8'h00) && (ps_num < 16'(N_PS_REGS));

	function automatic logic reg_known(input logic node, input logic [15:0] r);
		reg_known = node ? (r < 16'(N_NODE_REGS)) : (r < 16'(N_TILE_REGS));
	endfunction : reg_known

	always_comb begin
		next_ps_done = ps_valid;
		next_ps_error = ps_valid && !ps_ok;
		next_ps_rdata = ps_rdata;
		if (ps_valid && ps_ok && !ps_write) begin
			next_ps_rdata = ps_regs[ps_num[3:0]]; // R4
		end
	end

	always_comb begin
		next_state = state;
		next_is_write = is_write;
		next_is_node = is_node;
		next_bad = bad;
		next_count = count;
		next_chan = chan;
		next_regnum = regnum;
		next_data = data;
		next_rsp_idx = rsp_idx;
		next_rsp_len = rsp_len;
		next_req_ready = req_ready;
		next_rsp_valid = rsp_valid;
		next_rsp_ctrl = rsp_ctrl;
		next_rsp_byte = rsp_byte;
		next_do_write = 1'b0;
		case (state)
			S_IDLE: begin
				next_req_ready = 1'b1;
				if (take) begin
					next_bad = 1'b0;
					next_count = 3'd0;
					next_is_write = (link.req_byte == TOK_WRITE); // R8
					next_is_node = dest_match(link.req_dest, node_id,
						NODE_DEST_LOW); // R7
					if (!link.req_ctrl) begin
						next_state = S_IDLE;
					end else if (!(dest_match(link.req_dest, tile_id,
						TILE_DEST_LOW) || dest_match(link.req_dest, node_id,
						NODE_DEST_LOW))) begin
						next_state = S_IDLE; // R6
					end else if (link.req_byte == TOK_WRITE ||
						link.req_byte == TOK_READ) begin
						next_state = S_CHAN; // R9
					end
				end
			end
			S_CHAN, S_REG, S_DATA: begin
				if (take && link.req_ctrl) begin
					next_bad = 1'b1; // R12
					next_req_ready = (link.req_byte != TOK_END);
					next_state = (link.req_byte == TOK_END) ? S_REPLY : S_DRAIN;
					next_chan = (state == S_CHAN) ? 24'h0 : chan;
				end else if (take) begin
					next_count = count + 3'd1;
					if (state == S_CHAN) begin
						next_chan = {chan[15:0], link.req_byte}; // R1 R3
					end else if (state == S_REG) begin
						next_regnum = {regnum[7:0], link.req_byte}; // R3
					end else begin
						next_data = {data[23:0], link.req_byte}; // R3
					end
					// The channel field ends on its third byte, the register on its second.
					if ((state == S_CHAN && count == 3'd2) ||
						(state == S_REG && count == 3'd1) || count == 3'd3) begin
						next_count = 3'd0;
						next_state = (state == S_REG && is_write) ? S_DATA :
							(state == S_CHAN) ? S_REG : S_END;
					end
				end
			end
			S_END, S_DRAIN: begin
				if (take) begin
					if (link.req_ctrl && link.req_byte == TOK_END) begin
						next_state = S_REPLY;
						next_req_ready = 1'b0;
						if (state == S_END && !bad &&
							reg_known(is_node, regnum)) begin
							next_do_write = is_write; // R10
							if (!is_write) begin
								next_data = is_node ? node_regs[regnum[2:0]]
									: tile_regs[regnum[2:0]]; // R11
							end
						end else begin
							next_bad = 1'b1; // R12
						end
					end else if (state == S_END) begin
						next_bad = 1'b1; // R12
						next_state = S_DRAIN;
					end
				end
			end
			S_REPLY: begin
				next_req_ready = 1'b0;
				next_rsp_idx = 3'd0;
				next_rsp_len = (bad || is_write) ? 3'd2 : 3'd6;
				if (is_write && chan[7:0] == NO_REPLY_LOW) begin
					next_state = S_IDLE; // R2
					next_req_ready = 1'b1;
				end else if (!rsp_valid) begin
					next_rsp_valid = 1'b1;
					next_rsp_ctrl = 1'b1;
					next_rsp_byte = bad ? TOK_NACK : TOK_ACK; // R10 R11
				end else if (link.rsp_ready) begin
					next_rsp_idx = rsp_idx + 3'd1;
					next_rsp_len = rsp_len;
					if (rsp_idx + 3'd1 == rsp_len) begin
						next_rsp_valid = 1'b0;
						next_state = S_IDLE;
						next_req_ready = 1'b1;
					end else if (rsp_idx + 3'd2 == rsp_len) begin
						next_rsp_ctrl = 1'b1;
						next_rsp_byte = TOK_END;
					end else begin
						next_rsp_ctrl = 1'b0;
						next_rsp_byte = data[31:24]; // R3 R11
						next_data = {data[23:0], 8'h00};
					end
				end else begin
					next_rsp_len = rsp_len;
					next_rsp_idx = rsp_idx;
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			{is_write, is_node, bad, do_write, req_ready} <= 5'h00;
			{rsp_valid, rsp_ctrl, ps_done, ps_error, busy} <= 5'h00;
			{count, rsp_idx, rsp_len} <= 9'h000;
			{chan, regnum, rsp_byte} <= 48'h0000_0000_0000;
			data <= REG_RESET;
			ps_rdata <= REG_RESET;
		end else begin
			state <= next_state;
			{is_write, is_node, bad} <= {next_is_write, next_is_node, next_bad};
			count <= next_count;
			chan <= next_chan;
			regnum <= next_regnum;
			data <= next_data;
			{rsp_idx, rsp_len} <= {next_rsp_idx, next_rsp_len};
			req_ready <= next_req_ready;
			{rsp_valid, rsp_ctrl} <= {next_rsp_valid, next_rsp_ctrl};
			rsp_byte <= next_rsp_byte;
			do_write <= next_do_write;
			{ps_done, ps_error} <= {next_ps_done, next_ps_error};
			ps_rdata <= next_ps_rdata;
			busy <= (next_state != S_IDLE);
		end
	end

	// The write lands one cycle after the closing token, on the same edge that raises the reply's first byte.
	genvar i;
	generate
		for (i = 0; i < N_TILE_REGS; i++) begin : g_tile
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					tile_regs[i] <= REG_RESET;
				end else if (do_write && !is_node && regnum[2:0] == 3'(i)) begin
					tile_regs[i] <= data; // R6
				end
			end
		end
		for (i = 0; i < N_NODE_REGS; i++) begin : g_node
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					node_regs[i] <= REG_RESET;
				end else if (do_write && is_node && regnum[2:0] == 3'(i)) begin
					node_regs[i] <= data; // R7
				end
			end
		end
		for (i = 0; i < N_PS_REGS; i++) begin : g_ps
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					ps_regs[i] <= REG_RESET;
				end else if (ps_valid && ps_ok && ps_write &&
					ps_num[3:0] == 4'(i)) begin
					ps_regs[i] <= ps_wdata; // R4
				end
			end
		end
	endgenerate
endmodule : cfg_device
`default_nettype wire

// ==== design/cfg_requester.sv ====
// Requester end: turns one user command into a message and gathers the reply.
`timescale 1ns/10ps
`default_nettype none
module cfg_requester (
	input wire logic clock,
	input wire logic rst,
	cfg_link_if.requester link,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [31:0] cmd_dest,
	input wire logic [23:0] cmd_chan,
	input wire logic [15:0] cmd_reg,
	input wire logic [31:0] cmd_data,
	output logic cmd_ready,
	output logic done,
	output logic ok,
	output logic [31:0] rdata
);
	import cfg_msg_pkg::*;

	typedef enum logic [1:0] {
		Q_IDLE = 2'b00,
		Q_SEND = 2'b01,
		Q_WAIT = 2'b10
	} state_t;

	state_t state, next_state;
	logic [95:0] frame, next_frame;
	logic [10:0] ctrl_map, next_ctrl_map;
	logic [3:0] left, next_left;
	logic [31:0] dest, next_dest;
	logic first, next_first;
	logic silent, next_silent;
	logic next_cmd_ready, next_done, next_ok;
	logic [31:0] next_rdata;

	assign link.req_dest = dest;
	assign link.req_valid = (state == Q_SEND);
	assign link.req_ctrl = ctrl_map[10];
	assign link.req_byte = frame[95:88];
	assign link.rsp_ready = (state == Q_WAIT);

	always_comb begin
		next_state = state;
		next_frame = frame;
		next_ctrl_map = ctrl_map;
		next_left = left;
		next_dest = dest;
		next_first = first;
		next_silent = silent;
		next_cmd_ready = 1'b0;
		next_done = 1'b0;
		next_ok = ok;
		next_rdata = rdata;
		case (state)
			Q_IDLE: begin
				next_cmd_ready = 1'b1;
				if (cmd_valid && cmd_ready) begin
					next_cmd_ready = 1'b0;
					next_dest = cmd_dest; // R6 R7
					next_state = Q_SEND;
					next_silent = cmd_write && cmd_chan[7:0] == NO_REPLY_LOW; // R2
					if (cmd_write) begin
						next_frame = {TOK_WRITE, cmd_chan, cmd_reg, cmd_data,
							TOK_END, 8'h00}; // R8 R1 R3
						next_ctrl_map = 11'b10000000001;
						next_left = 4'd11;
					end else begin
						next_frame = {TOK_READ, cmd_chan, cmd_reg, TOK_END,
							40'h0}; // R9
						next_ctrl_map = 11'b10000010000;
						next_left = 4'd7;
					end
				end
			end
			Q_SEND: begin
				if (link.req_ready) begin
					next_frame = {frame[87:0], 8'h00};
					next_ctrl_map = {ctrl_map[9:0], 1'b0};
					next_left = left - 4'd1;
					if (left == 4'd1) begin
						next_first = 1'b1;
						next_rdata = 32'h0;
						if (silent) begin
							next_state = Q_IDLE;
							next_done = 1'b1;
							next_ok = 1'b1;
						end else begin
							next_state = Q_WAIT;
						end
					end
				end
			end
			Q_WAIT: begin
				if (link.rsp_valid) begin
					next_first = 1'b0;
					if (first) begin
						next_ok = link.rsp_ctrl && link.rsp_byte == TOK_ACK; // R10
					end else if (!link.rsp_ctrl) begin
						next_rdata = {rdata[23:0], link.rsp_byte}; // R11 R3
					end else if (link.rsp_byte == TOK_END) begin
						next_state = Q_IDLE;
						next_done = 1'b1;
					end
				end
			end
			default: begin
				next_state = Q_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= Q_IDLE;
			frame <= 96'h0;
			ctrl_map <= 11'h0;
			left <= 4'd0;
			dest <= 32'h0;
			first <= 1'b0;
			silent <= 1'b0;
			cmd_ready <= 1'b0;
			done <= 1'b0;
			ok <= 1'b0;
			rdata <= 32'h0;
		end else begin
			state <= next_state;
			frame <= next_frame;
			ctrl_map <= next_ctrl_map;
			left <= next_left;
			dest <= next_dest;
			first <= next_first;
			silent <= next_silent;
			cmd_ready <= next_cmd_ready;
			done <= next_done;
			ok <= next_ok;
			rdata <= next_rdata;
		end
	end
endmodule : cfg_requester
`default_nettype wire

// ==== bench/cfg_msg_assertions.sv ====
// Checker for the link that joins the requester and device ends.
`timescale 1ns/10ps
`default_nettype none
module cfg_msg_assertions
	import cfg_msg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_ctrl,
	input wire logic [7:0] req_byte,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic rsp_ctrl,
	input wire logic [7:0] rsp_byte,
	input wire logic [23:0] rsp_chan,
	input wire logic rsp_ready
);
	logic [2:0] idx, next_idx, dcnt, next_dcnt;
	logic is_write, next_is_write;
	logic [23:0] cap, next_cap;
	wire logic req_take = req_valid && req_ready;
	wire logic rsp_take = rsp_valid && rsp_ready;
	// The first three data bytes of a request are the reply channel-end.
	always_comb begin
		next_idx = idx;
		next_is_write = is_write;
		next_cap = cap;
		next_dcnt = dcnt;
		if (req_take && req_ctrl && req_byte != TOK_END) begin
			next_idx = 3'h0;
			next_is_write = (req_byte == TOK_WRITE);
		end else if (req_take && !req_ctrl && idx < 3'h3) begin
			next_idx = idx + 3'h1;
			next_cap = {cap[15:0], req_byte};
		end
		if (rsp_take && rsp_ctrl && rsp_byte != TOK_END)
			next_dcnt = 3'h0;
		else if (rsp_take && !rsp_ctrl)
			next_dcnt = dcnt + 3'h1;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idx <= 3'h0;
			is_write <= 1'b0;
			cap <= 24'h0;
			dcnt <= 3'h0;
		end else begin
			idx <= next_idx;
			is_write <= next_is_write;
			cap <= next_cap;
			dcnt <= next_dcnt;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_req_end;
		req_take && req_ctrl && req_byte == TOK_END;
	endsequence
	sequence s_rsp_end;
		rsp_take && rsp_ctrl && rsp_byte == TOK_END;
	endsequence
	property p_reply_start;
		s_req_end |-> ((is_write && cap[7:0] == NO_REPLY_LOW) or
			##[2:3] (rsp_valid && rsp_ctrl));
	endproperty
	a_reply_start: assert property (p_reply_start)
		else $error("reply did not start after closing token");
	property p_no_reply;
		s_req_end ##0 (is_write && cap[7:0] == NO_REPLY_LOW) |=>
			!rsp_valid [*4];
	endproperty
	a_no_reply: assert property (p_no_reply)
		else $error("reply sent for suppressed write");
	property p_first_tok;
		$rose(rsp_valid) |-> rsp_ctrl &&
			(rsp_byte == TOK_ACK || rsp_byte == TOK_NACK);
	endproperty
	a_first_tok: assert property (p_first_tok)
		else $error("reply does not open with status token");
	property p_chan;
		$rose(rsp_valid) |-> rsp_chan == cap;
	endproperty
	a_chan: assert property (p_chan)
		else $error("reply channel differs from request");
	property p_refuse;
		s_req_end |=> !req_ready;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("request taken right after closing token");
	property p_no_overlap;
		rsp_valid |-> !req_ready;
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("request accepted during reply");
	property p_nack_end;
		rsp_take && rsp_ctrl && rsp_byte == TOK_NACK |->
			##[1:3] (rsp_valid && rsp_ctrl && rsp_byte == TOK_END);
	endproperty
	a_nack_end: assert property (p_nack_end)
		else $error("failure reply not closed by end token");
	property p_data_count;
		s_rsp_end |-> (is_write ? dcnt == 3'h0 :
			(dcnt == 3'h0 || dcnt == 3'h4));
	endproperty
	a_data_count: assert property (p_data_count)
		else $error("wrong number of reply data bytes");
	property p_ready_back;
		s_rsp_end |-> ##[1:3] req_ready;
	endproperty
	a_ready_back: assert property (p_ready_back)
		else $error("device not ready after reply");
endmodule : cfg_msg_assertions
`default_nettype wire

// ==== bench/config_register_message_access_tb.sv ====
// Self-checking bench for the two link ends and the status register port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
	end end
module config_register_message_access_tb;
	import cfg_msg_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] tile_id, node_id, cmd_reg;
	logic ps_valid, ps_write, cmd_valid, cmd_write;
	logic [31:0] ps_resource, ps_wdata, cmd_dest, cmd_data, r;
	logic [23:0] cmd_chan;
	wire logic ps_done, ps_error, busy, cmd_ready, done, ok;
	wire logic [31:0] ps_rdata, rdata;
	int fail_count = 0;
	int tests_run = 0;
	logic [31:0] lfsr = 32'h6b2067cc;
	logic [31:0] tile_m [8];
	logic [31:0] node_m [8];
	logic [31:0] ps_m [16];
	cfg_link_if link ();
	cfg_link_if link2 ();
	cfg_device u_cfg_device (.clock(clock), .rst(rst), .link(link.device),
		.tile_id(tile_id), .node_id(node_id), .ps_valid(ps_valid),
		.ps_write(ps_write), .ps_resource(ps_resource), .ps_wdata(ps_wdata),
		.ps_done(ps_done), .ps_error(ps_error), .ps_rdata(ps_rdata),
		.busy(busy));
	// This second device faces the bench, which breaks the link rules.
	cfg_device u_cfg_device_b (.clock(clock), .rst(rst),
		.link(link2.device), .tile_id(tile_id), .node_id(node_id),
		.ps_valid(1'b0), .ps_write(1'b0), .ps_resource(32'h0),
		.ps_wdata(32'h0), .ps_done(), .ps_error(), .ps_rdata(), .busy());
	cfg_requester u_cfg_requester (.clock(clock), .rst(rst),
		.link(link.requester), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_dest(cmd_dest), .cmd_chan(cmd_chan), .cmd_reg(cmd_reg),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .ok(ok),
		.rdata(rdata));
	cfg_msg_assertions u_cfg_msg_assertions (.clock(clock), .rst(rst),
		.req_valid(link.req_valid), .req_ctrl(link.req_ctrl),
		.req_byte(link.req_byte), .req_ready(link.req_ready),
		.rsp_valid(link.rsp_valid), .rsp_ctrl(link.rsp_ctrl),
		.rsp_byte(link.rsp_byte), .rsp_chan(link.rsp_chan),
		.rsp_ready(link.rsp_ready));
	initial begin
		forever #20 clock = ~clock;
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	function automatic logic exp_ok(input logic [15:0] n);
		return n < 16'h8;
	endfunction : exp_ok
	function automatic logic [31:0] ps_res(input logic [31:0] n);
		return (n << PS_SHIFT) | {24'h0, PS_RES_TYPE};
	endfunction : ps_res
	task automatic do_cmd(input logic w, input logic nd, input logic [15:0] n,
		input logic [31:0] d, input logic [23:0] ch);
		int k;
		logic saw;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_reg = n;
		cmd_data = d;
		cmd_chan = ch;
		cmd_dest = nd ? {node_id, NODE_DEST_LOW} : {tile_id, TILE_DEST_LOW};
		@(posedge clock);
		while (!cmd_ready) @(posedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
		k = 0;
		saw = 1'b0;
		while (done !== 1'b1 && k < 60) begin
			@(negedge clock);
			saw = saw | busy;
			k++;
		end
		`CHK(done, 1'b1)
		`CHK(saw, 1'b1)
		if (ch[7:0] != NO_REPLY_LOW || !w) begin
			`CHK(ok, exp_ok(n))
			`CHK(link.rsp_chan, ch)
			if (!w && exp_ok(n))
				`CHK(rdata, nd ? node_m[n[2:0]] : tile_m[n[2:0]])
		end
		if (w && exp_ok(n) && nd)
			node_m[n[2:0]] = d;
		else if (w && exp_ok(n))
			tile_m[n[2:0]] = d;
		@(negedge clock);
		`CHK(busy, 1'b0)
	endtask : do_cmd
	task automatic ps_op(input logic w, input logic [31:0] res,
		input logic [31:0] d);
		logic bad;
		int k;
		bad = res[7:0] != PS_RES_TYPE || res[31:8] >= N_PS_REGS;
		@(negedge clock);
		ps_valid = 1'b1;
		ps_write = w;
		ps_resource = res;
		ps_wdata = d;
		@(negedge clock);
		ps_valid = 1'b0;
		k = 0;
		while (ps_done !== 1'b1 && k < 2) begin
			@(negedge clock);
			k++;
		end
		`CHK(ps_done, 1'b1)
		`CHK(ps_error, bad)
		if (!w && !bad)
			`CHK(ps_rdata, ps_m[res[11:8]])
		if (w && !bad)
			ps_m[res[11:8]] = d;
	endtask : ps_op
	task automatic send(input logic c, input logic [7:0] b);
		@(negedge clock);
		link2.req_valid = 1'b1;
		link2.req_ctrl = c;
		link2.req_byte = b;
		@(posedge clock);
		while (!link2.req_ready) @(posedge clock);
	endtask : send
	task automatic msg(input logic [7:0] tok, input logic [23:0] ch,
		input logic [47:0] v, input int nb);
		send(1'b1, tok);
		for (int i = 0; i < 3; i++) send(1'b0, ch[23 - 8 * i -: 8]);
		for (int i = 0; i < nb; i++) send(1'b0, v[47 - 8 * i -: 8]);
		send(1'b1, TOK_END);
		@(negedge clock);
		link2.req_valid = 1'b0;
		link2.req_byte = ~link2.req_byte;
	endtask : msg
	task automatic expect_rsp(input logic c, input logic [7:0] b);
		int k;
		k = 0;
		@(posedge clock);
		while (link2.rsp_valid !== 1'b1 && k < 10) begin
			@(posedge clock);
			k++;
		end
		`CHK({link2.rsp_valid, link2.rsp_ctrl, link2.rsp_byte}, {1'b1, c, b})
	endtask : expect_rsp
	task automatic read2(input logic [31:0] dest, input logic [31:0] e);
		link2.req_dest = dest;
		msg(TOK_READ, 24'h00_0a_01, 48'h0, 2);
		expect_rsp(1'b1, TOK_ACK);
		for (int i = 0; i < 4; i++) expect_rsp(1'b0, e[31 - 8 * i -: 8]);
		expect_rsp(1'b1, TOK_END);
	endtask : read2
	task automatic tally_and_finish();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Roughly 150 link commands of about 17 cycles each, with wide margin.
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		r = rnd();
		tile_id = r[15:0];
		node_id = r[31:16];
		{ps_valid, ps_write, cmd_valid, cmd_write} = 4'h0;
		{ps_resource, ps_wdata, cmd_dest, cmd_data} = 128'h0;
		{cmd_chan, cmd_reg} = 40'h0;
		{link2.req_valid, link2.req_ctrl, link2.req_byte} = 10'h0;
		link2.req_dest = 32'h0;
		link2.rsp_ready = 1'b1;
		for (int i = 0; i < 16; i++) ps_m[i] = REG_RESET;
		for (int i = 0; i < 8; i++) tile_m[i] = REG_RESET;
		for (int i = 0; i < 8; i++) node_m[i] = REG_RESET;
		repeat (10) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		do_cmd(1'b1, 1'b0, 16'h0007, 32'hdeadbeef, 24'h1234ff);
		do_cmd(1'b0, 1'b0, 16'h0007, 32'h0, 24'h123456);
		do_cmd(1'b0, 1'b1, 16'h0007, 32'h0, 24'h000001);
		do_cmd(1'b1, 1'b1, 16'h0008, 32'h1, 24'h0a0b0c);
		do_cmd(1'b0, 1'b0, 16'hffff, 32'h0, 24'h0a0b0c);
		for (int i = 0; i < 150; i++) begin
			r = rnd();
			do_cmd(r[0], r[1], {12'h0, r[3] & r[4], r[7:5]}, rnd(),
				r[9] ? {r[31:16], 8'hff} : r[31:8]);
		end
		for (int i = 0; i < 18; i++) begin
			ps_op(1'b0, ps_res(i), 32'h0);
			ps_op(1'b1, ps_res(i), rnd());
			ps_op(1'b0, ps_res(i), 32'h0);
		end
		ps_op(1'b0, 32'h0000_010c, 32'h0);
		// A wrong tile number or low pattern must leave no trace.
		link2.req_dest = {tile_id ^ 16'h0001, TILE_DEST_LOW};
		msg(TOK_WRITE, 24'h00_0a_01, 48'h0000_5a5a_5a5a, 6);
		link2.req_dest = {tile_id, TILE_DEST_LOW + 16'h0001};
		msg(TOK_WRITE, 24'h00_0a_01, 48'h0000_5a5a_5a5a, 6);
		r = 32'h0;
		repeat (8) begin
			@(posedge clock);
			r[0] = r[0] | link2.rsp_valid;
		end
		`CHK(r[0], 1'b0)
		read2({tile_id, TILE_DEST_LOW}, REG_RESET);
		link2.req_dest = {tile_id, TILE_DEST_LOW};
		msg(TOK_WRITE, 24'h00_0a_01, 48'h0000_1122_3344, 6);
		expect_rsp(1'b1, TOK_ACK);
		expect_rsp(1'b1, TOK_END);
		read2({tile_id, TILE_DEST_LOW}, 32'h1122_3344);
		read2({node_id, NODE_DEST_LOW}, REG_RESET);
		msg(TOK_READ, 24'h00_0a_01, 48'h0000_0000_0000, 1);
		expect_rsp(1'b1, TOK_NACK);
		expect_rsp(1'b1, TOK_END);
		send(1'b1, TOK_READ);
		msg(TOK_ACK, 24'h00_0a_01, 48'h0, 0);
		expect_rsp(1'b1, TOK_NACK);
		expect_rsp(1'b1, TOK_END);
		tally_and_finish();
	end
endmodule : config_register_message_access_tb
`default_nettype wire
